// File: tb/adcdm_capture_model.sv
`timescale 1ns/10ps
`include "adcdm_consts.vh"
// Far-side capture logic latching both buses off the half-rate clock
module adcdm_capture_model (
   // Clock and link
   input wire sys_clk_in,
   input wire half_rate_clock_in,
   input wire [`ADCDM_DATA_W-1:0] bus_first_in,
   input wire [`ADCDM_DATA_W-1:0] bus_second_in,
   // Captured pair
   output reg [`ADCDM_DATA_W-1:0] first_out,
   output reg [`ADCDM_DATA_W-1:0] second_out,
   output reg pair_stb_out
);
   reg clk_prev_q = 1'b0;
   // Latch the first bus on the clock fall and the second bus on the rise, where each is steady
   always @(posedge sys_clk_in) begin
      clk_prev_q <= half_rate_clock_in;
      pair_stb_out <= half_rate_clock_in && !clk_prev_q;
      if (clk_prev_q && !half_rate_clock_in) begin
         first_out <= bus_first_in;
      end
      if (half_rate_clock_in && !clk_prev_q) begin
         second_out <= bus_second_in;
      end
   end
endmodule

// File: tb/adcdm_top_properties.sv
`timescale 1ns/10ps
`include "adcdm_consts.vh"
// Port-level checks on the demux output side
module adcdm_top_properties (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Inputs
   input wire sample_clk_in,
   input wire [`ADCDM_DATA_W-1:0] sample_data_in,
   input wire sample_sync_in,
   input wire interleave_mode_in,
   input wire output_format_select_in,
   // Outputs
   input wire [`ADCDM_DATA_W-1:0] bus_first_out,
   input wire [`ADCDM_DATA_W-1:0] bus_second_out,
   input wire half_rate_clock_out,
   input wire half_rate_clock_n_out,
   input wire overflow_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // Sync is checked after 8 cycles high, so the pin filter has settled
   a_clk_pair_compl: assert property (
      half_rate_clock_n_out != half_rate_clock_out)
      else $error("clock pair not complementary");
   a_reset_clear: assert property ($fell(rst_in) |->
      bus_first_out == 10'h000 && bus_second_out == 10'h000 &&
      !half_rate_clock_out) else $error("outputs not cleared by reset");
   a_first_on_rise: assert property (
      $changed(bus_first_out) |-> $rose(half_rate_clock_out))
      else $error("first bus moved off a clock rise");
   a_second_il_fall: assert property (
      interleave_mode_in && $changed(bus_second_out) |->
      $fell(half_rate_clock_out)) else $error("second bus off clock fall");
   a_second_par_pair: assert property (
      !interleave_mode_in && $changed(bus_second_out) |->
      $changed(bus_first_out)) else $error("parallel buses not together");
   a_sync_freeze: assert property (sample_sync_in [*8] |=>
      $stable(bus_first_out) && $stable(bus_second_out) &&
      $stable(half_rate_clock_out)) else $error("outputs moved under sync");
   a_clk_spacing: assert property (
      $changed(half_rate_clock_out) |=> !$changed(half_rate_clock_out) [*3])
      else $error("half-rate clock toggled too soon");
   a_first_hold: assert property (
      $changed(bus_first_out) |=> $stable(bus_first_out) [*8])
      else $error("first bus updated on consecutive samples");
   c_il_second: cover property (interleave_mode_in && $changed(bus_second_out));
   c_par_second: cover property (!interleave_mode_in && $changed(bus_second_out));
   c_sync_hold: cover property (sample_sync_in [*8]);
endmodule
bind adcdm_top adcdm_top_properties u_adcdm_top_properties (
   .sys_clk_in, .rst_in, .sample_clk_in, .sample_data_in, .sample_sync_in,
   .interleave_mode_in, .output_format_select_in, .bus_first_out,
   .bus_second_out, .half_rate_clock_out, .half_rate_clock_n_out,
   .overflow_out
);

// File: tb/adcdm_top_tb.sv
`timescale 1ns/10ps
module adcdm_top_tb;
   reg sys_clk, rst, smp_clk, sync, il, fmt, p_hold, p_gate;
   reg [9:0] din;
   wire [9:0] b1, b2, c1, c2, b1p, b2p;
   wire hclk, hclk_n, ovf, stb, hclkp, ovfp, sync_p;
   integer n_mismatch, n_tests, cnt;

   // Block, far-side capture, and a peer block synced off the half-rate clock
   adcdm_top u_adcdm_top (.sys_clk_in(sys_clk), .rst_in(rst),
      .sample_clk_in(smp_clk), .sample_data_in(din), .sample_sync_in(sync),
      .interleave_mode_in(il), .output_format_select_in(fmt),
      .bus_first_out(b1), .bus_second_out(b2), .half_rate_clock_out(hclk),
      .half_rate_clock_n_out(hclk_n), .overflow_out(ovf));
   adcdm_capture_model u_adcdm_capture_model (.sys_clk_in(sys_clk),
      .half_rate_clock_in(hclk), .bus_first_in(b1), .bus_second_in(b2),
      .first_out(c1), .second_out(c2), .pair_stb_out(stb));
   adcdm_top u_adcdm_top_peer (.sys_clk_in(sys_clk), .rst_in(rst),
      .sample_clk_in(smp_clk), .sample_data_in(din), .sample_sync_in(sync_p),
      .interleave_mode_in(il), .output_format_select_in(fmt),
      .bus_first_out(b1p), .bus_second_out(b2p), .half_rate_clock_out(hclkp),
      .half_rate_clock_n_out(), .overflow_out(ovfp));
   // Peer sync: held high, or a gated copy of the half-rate clock
   assign sync_p = p_hold | (p_gate & hclk);

   // System clock and a sample clock of unrelated phase
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      smp_clk = 1'b0;
      #3;
      forever #32 smp_clk = ~smp_clk;
   end
   // Word value is its sample index; held 6 cycles past the rise
   always @(posedge smp_clk) begin
      cnt = cnt + 1;
      repeat (6) @(negedge sys_clk);
      din <= 10'(cnt + 1);
   end

   function [9:0] enc(input integer k);
      enc = 10'(k) ^ (fmt ? 10'h200 : 10'h000);
   endfunction
   task chk_word(input [9:0] got, input [9:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task chk_bit(input got, input exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Straps change only under sync; release lands just after a sample edge
   task restart(input m, input f, output integer n0);
      @(negedge sys_clk);
      sync = 1'b1;
      il = m;
      fmt = f;
      repeat (4) @(posedge smp_clk);
      repeat (2) @(negedge sys_clk);
      sync = 1'b0;
      n0 = cnt + 1;
   endtask
   // Every bus update is tied to the sample index seen at that moment
   task watch(input integer n0);
      reg [9:0] pf, ps, fl;
      reg sf, ss;
      integer i;
      pf = b1;
      ps = b2;
      sf = 1'b0;
      ss = 1'b0;
      fl = fmt ? 10'h200 : 10'h000;
      for (i = 0; i < 160; i = i + 1) begin
         @(negedge sys_clk);
         if (b1 !== pf) begin
            chk_word(b1, enc(cnt - 6));
            if (!sf) chk_word(b1, enc(n0));
            if (!sf) chk_bit(hclk, 1'b1);
            sf = 1'b1;
            pf = b1;
         end
         if (b2 !== ps) begin
            chk_word(b2, enc(il ? cnt - 6 : cnt - 7));
            if (!ss) chk_word(b2, enc(n0 + 1));
            ss = 1'b1;
            ps = b2;
         end
         if (stb && cnt >= n0 + 10) chk_word(c2 ^ fl, (c1 ^ fl) + 1);
      end
      chk_bit(sf & ss, 1'b1);
   endtask

   task t_reset;
      chk_word(b1, 10'h000);
      chk_word(b2, 10'h000);
      chk_bit(hclk, 1'b0);
      chk_bit(hclk_n, 1'b1);
   endtask
   task t_interleave;
      integer n0;
      restart(1'b1, 1'b0, n0);
      watch(n0);
   endtask
   task t_parallel;
      integer n0;
      restart(1'b0, 1'b1, n0);
      watch(n0);
   endtask
   task t_sync_freeze;
      reg [9:0] v1, v2;
      reg h;
      @(negedge sys_clk);
      sync = 1'b1;
      repeat (2) @(posedge smp_clk);
      @(negedge sys_clk);
      v1 = b1;
      v2 = b2;
      h = hclk;
      repeat (6) @(posedge smp_clk);
      @(negedge sys_clk);
      chk_word(b1, v1);
      chk_word(b2, v2);
      chk_bit(hclk, h);
   endtask
   // Peer's sync is a gated copy of the half-rate clock; the sample edge after its fall is edge N
   task t_chain;
      reg [9:0] pf, ps;
      integer i;
      @(negedge sys_clk);
      while (hclk !== 1'b1) @(negedge sys_clk);
      p_gate = 1'b1;
      p_hold = 1'b0;
      while (hclk !== 1'b0) @(negedge sys_clk);
      p_gate = 1'b0;
      pf = b1p;
      ps = b2p;
      for (i = 0; i < 120; i = i + 1) begin
         @(negedge sys_clk);
         if (i >= 72) chk_bit(hclkp, hclk);
         if (i >= 72 && b1p !== pf) chk_word(b1p, enc(cnt - 6));
         if (i >= 72 && b2p !== ps) chk_word(b2p, enc(cnt - 6));
         pf = b1p;
         ps = b2p;
      end
      chk_word(b1p, b1);
      // Freeze the peer again so later strap changes happen under its sync
      p_hold = 1'b1;
   endtask
   // FIFO seen through the pins: a steady stream never fills it
   task t_fifo;
      chk_bit(ovf, 1'b0);
      chk_bit(ovfp, 1'b0);
   endtask

   // Main sequence
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      cnt = -1;
      {rst, sync, il, fmt, p_hold, p_gate} = 6'b10_1010;
      din = 10'h000;
      repeat (5) @(negedge sys_clk);
      t_reset;
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      t_interleave;
      t_chain;
      t_sync_freeze;
      t_parallel;
      t_fifo;
      complete_run;
   end
   // Whole run needs about 5 us
   initial begin
      #100000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
endmodule

// File: verilog/adcdm_consts.vh
`ifndef ADCDM_CONSTS_VH
`define ADCDM_CONSTS_VH

// Sample word width and FIFO shape
`define ADCDM_DATA_W 10
`define ADCDM_WORD_W 11
`define ADCDM_FIFO_DEPTH 32
`define ADCDM_FIFO_AW 5

// Latency in sample-clock edges, capture edge to bus update
`define ADCDM_LAT_FIRST 6
`define ADCDM_LAT_SECOND_PAR 7
// Edges spent in the FIFO stage plus the output register
`define ADCDM_LAT_FIXED 1
// Delay-line stages between FIFO and output register
`define ADCDM_PIPE_DEPTH (`ADCDM_LAT_FIRST - `ADCDM_LAT_FIXED)

// Bit positions inside the filtered pin vector
`define ADCDM_PIN_W 4
`define ADCDM_PIN_CLK 0
`define ADCDM_PIN_SYNC 1
`define ADCDM_PIN_MODE 2
`define ADCDM_PIN_FMT 3

// Bit position of the bus tag inside a FIFO word
`define ADCDM_TAG_BIT 10

// Output coding: midscale codes and the mask that maps one onto the other
`define ADCDM_MID_OFFSET 10'h200
`define ADCDM_MID_TWOS 10'h000
`define ADCDM_FMT_FLIP (`ADCDM_MID_OFFSET ^ `ADCDM_MID_TWOS)

// Reset values
`define ADCDM_BUS_RST 10'h000
`define ADCDM_PH_RST 1'b0

`endif

// File: verilog/adcdm_fifo.v
`timescale 1ns/10ps
`include "adcdm_consts.vh"

// Word FIFO in flip-flops, first-word-fall-through on the read side
module adcdm_fifo #(
   parameter WIDTH = `ADCDM_WORD_W,
   parameter DEPTH = `ADCDM_FIFO_DEPTH,
   parameter AW = `ADCDM_FIFO_AW
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Fill side
   input wire [WIDTH-1:0] wr_data_in,
   input wire wr_valid_in,
   output wire wr_ready_out,
   // Drain side
   output wire [WIDTH-1:0] rd_data_out,
   output wire rd_valid_out,
   input wire rd_ready_in
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW:0] wr_ptr_q;
   reg [AW:0] rd_ptr_q;
   wire full;
   wire empty;
   wire do_wr;
   wire do_rd;

   // Extra pointer bit tells full from empty when the indices meet
   assign empty = (wr_ptr_q == rd_ptr_q);
   assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                 (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign do_wr = wr_valid_in & ~full;
   assign do_rd = rd_ready_in & ~empty;
   assign wr_ready_out = ~full;
   assign rd_valid_out = ~empty;
   assign rd_data_out = mem_q[rd_ptr_q[AW-1:0]];

   // Storage write; no reset needed since empty masks stale words
   always @(posedge sys_clk_in) begin
      if (do_wr) begin
         mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
      end
   end

   // Pointers
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_ptr_q <= {(AW+1){1'b0}};
         rd_ptr_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

endmodule

// File: verilog/adcdm_top.v
`timescale 1ns/10ps
`include "adcdm_consts.vh"

// Function
// - Drive complementary output clock pair at half the sample clock rate.
// - Send successive samples alternately to the two output buses.
// - Interleaved mode: sample reaches its bus six edges after capture.
// - Parallel mode: second bus gets seven edges so both buses change together.
// - While sync is high, both buses and output clock stay static.
// - First sample edge after sync falls is edge N; fixes bus assignment.
// - Sample N appears on first bus six edges later, interleaved mode.
// - Sample N+1 appears on second bus six edges after its edge, interleaved mode.
// - Parallel mode: N on first bus at six, N+1 on second at seven.
// - Mode pin low selects parallel timing, high selects interleaved.
// - Output words in offset binary or twos complement per format select.
//
// The converter core, sample clock, sync and straps all arrive from outside
// this clock domain. sys_clk_in oversamples them, so the sample clock must
// be well below a quarter of sys_clk_in.
module adcdm_top (
   // System clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // Sample clock and raw sample word from the converter core
   input wire sample_clk_in,
   input wire [`ADCDM_DATA_W-1:0] sample_data_in,
   // Control pins
   input wire sample_sync_in,
   input wire interleave_mode_in,
   input wire output_format_select_in,
   // Output buses: first bus (port B) and second bus (port A)
   output reg [`ADCDM_DATA_W-1:0] bus_first_out,
   output reg [`ADCDM_DATA_W-1:0] bus_second_out,
   // Half-rate output clock pair
   output reg half_rate_clock_out,
   output reg half_rate_clock_n_out,
   // Capture stalled because the FIFO was full
   output reg overflow_out
);

   // Pin synchronisers: three stages, then a change filter
   reg [`ADCDM_PIN_W-1:0] pin_s1_q;
   reg [`ADCDM_PIN_W-1:0] pin_s2_q;
   reg [`ADCDM_PIN_W-1:0] pin_s3_q;
   reg [`ADCDM_PIN_W-1:0] pin_f_q;
   wire [`ADCDM_PIN_W-1:0] pin_raw;
   wire [`ADCDM_PIN_W-1:0] pin_agree;
   wire [`ADCDM_PIN_W-1:0] pin_f_d;

   // Data word follows the sample clock through the same depth
   reg [`ADCDM_DATA_W-1:0] dat_s1_q;
   reg [`ADCDM_DATA_W-1:0] dat_s2_q;
   reg [`ADCDM_DATA_W-1:0] dat_s3_q;

   // Decoded sample-clock edge and filtered levels
   wire edge_now;
   wire sync_hi;
   wire mode_il;
   wire fmt_twos;

   // Phase and sync tracking
   reg ph_q;
   reg ph_d;
   reg armed_q;
   reg armed_d;
   reg cap_tag;

   // FIFO ports
   wire [`ADCDM_WORD_W-1:0] fifo_wr_data;
   wire fifo_wr_valid;
   wire fifo_wr_ready;
   wire [`ADCDM_WORD_W-1:0] fifo_rd_data;
   wire fifo_rd_valid;
   wire fifo_rd_ready;

   // Delay line between FIFO and output register
   reg [`ADCDM_WORD_W-1:0] pipe_q [0:`ADCDM_PIPE_DEPTH-1];
   reg [`ADCDM_PIPE_DEPTH-1:0] pipe_v_q;
   wire [`ADCDM_WORD_W-1:0] pipe_last;
   wire pipe_last_v;
   integer i;

   // Extra edge of delay for the second bus in parallel mode
   reg [`ADCDM_DATA_W-1:0] hold_q;
   reg hold_v_q;

   // Output stage next values
   reg [`ADCDM_DATA_W-1:0] bus_first_d;
   reg [`ADCDM_DATA_W-1:0] bus_second_d;
   reg [`ADCDM_DATA_W-1:0] hold_d;
   reg hold_v_d;
   reg clk_d;

   // Format conversion: twos complement is offset binary with MSB flipped
   function [`ADCDM_DATA_W-1:0] adcdm_code;
      input [`ADCDM_DATA_W-1:0] raw;
      input twos;
      begin
         adcdm_code = twos ? (raw ^ `ADCDM_FMT_FLIP) : raw;
      end
   endfunction

   // Pin vector in fixed bit order
   assign pin_raw[`ADCDM_PIN_CLK] = sample_clk_in;
   assign pin_raw[`ADCDM_PIN_SYNC] = sample_sync_in;
   assign pin_raw[`ADCDM_PIN_MODE] = interleave_mode_in;
   assign pin_raw[`ADCDM_PIN_FMT] = output_format_select_in;

   // A change counts only when the second and third stages agree
   assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
   assign pin_f_d = (pin_agree & pin_s3_q) | (~pin_agree & pin_f_q);

   // Synchroniser chain; the first stage feeds only the second
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pin_s1_q <= {`ADCDM_PIN_W{1'b0}};
         pin_s2_q <= {`ADCDM_PIN_W{1'b0}};
         pin_s3_q <= {`ADCDM_PIN_W{1'b0}};
         pin_f_q <= {`ADCDM_PIN_W{1'b0}};
         dat_s1_q <= `ADCDM_BUS_RST;
         dat_s2_q <= `ADCDM_BUS_RST;
         dat_s3_q <= `ADCDM_BUS_RST;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q <= pin_f_d;
         dat_s1_q <= sample_data_in;
         dat_s2_q <= dat_s1_q;
         dat_s3_q <= dat_s2_q;
      end
   end

   // Rising sample-clock edge: filtered level goes from low to high
   assign edge_now = pin_f_d[`ADCDM_PIN_CLK] & ~pin_f_q[`ADCDM_PIN_CLK];
   assign sync_hi = pin_f_q[`ADCDM_PIN_SYNC];
   assign mode_il = pin_f_q[`ADCDM_PIN_MODE];
   assign fmt_twos = pin_f_q[`ADCDM_PIN_FMT];

   // Phase of the current capture edge. The first edge with sync low after
   // a high spell is edge N: it takes tag 0 and the phase restarts there.
   always @* begin
      ph_d = ph_q;
      armed_d = armed_q;
      cap_tag = ph_q;
      if (edge_now) begin
         if (sync_hi) begin
            armed_d = 1'b1;
         end else if (armed_q) begin
            cap_tag = 1'b0;
            ph_d = 1'b1;
            armed_d = 1'b0;
         end else begin
            ph_d = ~ph_q;
         end
      end
   end

   // Phase registers; after reset the block waits for an edge N
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         ph_q <= `ADCDM_PH_RST;
         armed_q <= 1'b1;
      end else begin
         ph_q <= ph_d;
         armed_q <= armed_d;
      end
   end

   // Capture: one word per sample edge while sync is low, tagged with
   // its bus. A full FIFO stalls capture and the sample is dropped.
   assign fifo_wr_data = {cap_tag, dat_s3_q};
   assign fifo_wr_valid = edge_now & ~sync_hi;

   // Drain one word per sample edge; during sync high words are flushed
   assign fifo_rd_ready = edge_now;

   adcdm_fifo #(
      .WIDTH(`ADCDM_WORD_W),
      .DEPTH(`ADCDM_FIFO_DEPTH),
      .AW(`ADCDM_FIFO_AW)
   ) u_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .wr_data_in(fifo_wr_data),
      .wr_valid_in(fifo_wr_valid),
      .wr_ready_out(fifo_wr_ready),
      .rd_data_out(fifo_rd_data),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready)
   );

   // Sticky flag for samples lost to a full FIFO, cleared by reset only
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         overflow_out <= 1'b0;
      end else if (fifo_wr_valid & ~fifo_wr_ready) begin
         overflow_out <= 1'b1;
      end
   end

   // Delay line advances on each sample edge. Sync high clears the valid
   // bits so that no stale word leaks out after the next edge N.
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         pipe_v_q <= {`ADCDM_PIPE_DEPTH{1'b0}};
      end else if (edge_now) begin
         if (sync_hi) begin
            pipe_v_q <= {`ADCDM_PIPE_DEPTH{1'b0}};
         end else begin
            pipe_v_q <= {pipe_v_q[`ADCDM_PIPE_DEPTH-2:0], fifo_rd_valid};
         end
      end
   end

   // Delay-line data; word only matters where its valid bit is set
   always @(posedge sys_clk_in) begin
      if (edge_now & ~sync_hi) begin
         pipe_q[0] <= fifo_rd_data;
         for (i = 1; i < `ADCDM_PIPE_DEPTH; i = i + 1) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   assign pipe_last = pipe_q[`ADCDM_PIPE_DEPTH-1];
   assign pipe_last_v = pipe_v_q[`ADCDM_PIPE_DEPTH-1];

   // Output stage: steer by tag, apply coding, run the half-rate clock
   always @* begin
      bus_first_d = bus_first_out;
      bus_second_d = bus_second_out;
      hold_d = hold_q;
      hold_v_d = hold_v_q;
      clk_d = half_rate_clock_out;
      if (edge_now & ~sync_hi) begin
         // Restart with the phase so the clock rises with first-bus data
         clk_d = ph_d;
         if (armed_q) begin
            clk_d = 1'b1;
         end
         // Parallel mode: the held word reaches the second bus one edge late
         if (hold_v_q) begin
            bus_second_d = adcdm_code(hold_q, fmt_twos);
            hold_v_d = 1'b0;
         end
         if (pipe_last_v) begin
            if (~pipe_last[`ADCDM_TAG_BIT]) begin
               bus_first_d = adcdm_code(pipe_last[`ADCDM_DATA_W-1:0],
                                        fmt_twos);
            end else if (mode_il) begin
               bus_second_d = adcdm_code(pipe_last[`ADCDM_DATA_W-1:0],
                                         fmt_twos);
            end else begin
               hold_d = pipe_last[`ADCDM_DATA_W-1:0];
               hold_v_d = 1'b1;
            end
         end
      end
   end

   // Output registers; only the held-word valid bit moves while sync is high
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         bus_first_out <= `ADCDM_BUS_RST;
         bus_second_out <= `ADCDM_BUS_RST;
         hold_q <= `ADCDM_BUS_RST;
         hold_v_q <= 1'b0;
         half_rate_clock_out <= 1'b0;
         half_rate_clock_n_out <= 1'b1;
      end else begin
         bus_first_out <= bus_first_d;
         bus_second_out <= bus_second_d;
         hold_q <= hold_d;
         // A held word is dropped on sync so it cannot slip past edge N
         hold_v_q <= hold_v_d & ~(edge_now & sync_hi);
         half_rate_clock_out <= clk_d;
         half_rate_clock_n_out <= ~clk_d;
      end
   end

endmodule
